// [pfs_map.svh]
// Purpose: Register indices, field positions, reset values and mode codes for the port function select block.
// Assumes: Registers sit at word-aligned byte address four times their index.
// Notes: Definitions only.
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

`define PFS_ADR_W          18
`define PFS_IDX_W          16
`define PFS_IDX_P1_DIR     16'hff44
`define PFS_IDX_P1_PUL     16'hff45
`define PFS_IDX_P1_DAT     16'hff46
`define PFS_IDX_P2_DIR     16'hff48
`define PFS_IDX_P2_PUL     16'hff49
`define PFS_IDX_P2_DAT     16'hff4a
`define PFS_IDX_LCD_SEL    16'hff61
`define PFS_IDX_SER_MODE   16'hff70

`define PFS_BIT_LCD_SEL    3
`define PFS_BIT_SER_EN     0
`define PFS_BIT_MODE_LO    1
`define PFS_BIT_MODE_HI    2

`define PFS_RST_LCD_SEL    1'h0
`define PFS_RST_SER_EN     1'h0
`define PFS_RST_MODE       2'h0
`define PFS_RST_DAT        4'h0
`define PFS_RST_DIR        4'h0
`define PFS_RST_PUL        4'hf

`define PFS_MODE_SYNC_MST  2'h0
`define PFS_MODE_SYNC_SLV  2'h1
`define PFS_MODE_ASYNC7    2'h2
`define PFS_MODE_ASYNC8    2'h3

`define PFS_CLAIM_SLAVE    4'hf
`define PFS_CLAIM_MASTER   4'h7
`define PFS_CLAIM_ASYNC    4'h3
`define PFS_CLAIM_NONE     4'h0
`define PFS_CLAIM_LCD      4'hc
`define PFS_LCD_SYNC_BIT   2
`define PFS_LCD_FRAME_BIT  3

`endif

// [pfs_pkg.sv]
// Purpose: Shared types of the port function select block.
// Assumes: Mode codes match the two-bit serial mode field.
// Notes: Constants live in pfs_map.svh.
`default_nettype none

package pfs_pkg;

  typedef enum logic [1:0] {
    PFS_SYNC_MASTER = 2'b00,
    PFS_SYNC_SLAVE  = 2'b01,
    PFS_ASYNC_7BIT  = 2'b10,
    PFS_ASYNC_8BIT  = 2'b11
  } pfs_serial_mode_t;

  typedef logic [3:0] pfs_nibble_t;

endpackage : pfs_pkg

`default_nettype wire

// [pfs_pin_slot.sv]
// Purpose: One port pin that is handed either to its general-purpose port logic or to an alternate function.
// Assumes: All inputs synchronous to clk_i.
// Notes: Outputs are registered, so the pin follows its source one clock later.
`timescale 1ns/10ps
`default_nettype none

module pfs_pin_slot (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic claim_i,
  input  wire logic alt_out_i,
  input  wire logic alt_oe_i,
  input  wire logic alt_pu_i,
  input  wire logic gpio_out_i,
  input  wire logic gpio_oe_i,
  input  wire logic gpio_pu_i,
  output logic      pin_out_o,
  output logic      pin_oe_o,
  output logic      pin_pu_o
);

  // While claimed, gpio_out_i, gpio_oe_i and gpio_pu_i have no say in the pin at all.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o  <= 1'b0;
      pin_pu_o  <= 1'b0;
    end else if (claim_i) begin
      pin_out_o <= alt_out_i;
      pin_oe_o  <= alt_oe_i;
      pin_pu_o  <= alt_pu_i;
    end else begin
      pin_out_o <= gpio_out_i;
      pin_oe_o  <= gpio_oe_i;
      pin_pu_o  <= gpio_pu_i;
    end
  end

endmodule // pfs_pin_slot

`default_nettype wire

// [pfs_port_function_select.sv]
// What this block does
// RQ1 - LCD select routes line sync, frame to pins.
// RQ2 - LCD signals appear on pins without sequencing.
// RQ3 - Claimed pins' data and direction bits are plain storage.
// RQ4 - LCD select resets to zero, reads back.
// RQ5 - Serial enable picks serial or port use.
// RQ6 - Mode 2 async 7-bit, 3 async 8-bit.
// RQ7 - Mode 0 sync master, 1 sync slave.
// RQ8 - Mode sets how many port-1 pins serial claims.
// RQ9 - Serial mode register top bit reads zero.
//
// Purpose: Pin function selection for port 1 (serial interface) and port 2 (LCD expansion signals).
// Assumes: Classic Wishbone slave, 32-bit data; register at byte address four times its index.
// Notes: Pin outputs are registered, so every pin follows its source one clock later.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_map.svh"

module pfs_port_function_select #(
  parameter int DATA_W = 32
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`PFS_ADR_W-1:0]    wb_adr_i,
  input  wire logic [DATA_W/8-1:0]      wb_sel_i,
  input  wire logic [DATA_W-1:0]        wb_dat_i,
  output logic      [DATA_W-1:0]        wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     lcd_line_sync_i,
  input  wire logic                     lcd_frame_signal_i,
  input  wire pfs_pkg::pfs_nibble_t     sio_out_i,
  input  wire pfs_pkg::pfs_nibble_t     sio_oe_i,
  output pfs_pkg::pfs_nibble_t          sio_in_o,
  output logic                          serial_enable_o,
  output pfs_pkg::pfs_serial_mode_t     serial_mode_o,
  output logic                          lcd_expansion_select_o,
  input  wire pfs_pkg::pfs_nibble_t     p1_in_i,
  output pfs_pkg::pfs_nibble_t          p1_out_o,
  output pfs_pkg::pfs_nibble_t          p1_oe_o,
  output pfs_pkg::pfs_nibble_t          p1_pu_o,
  input  wire pfs_pkg::pfs_nibble_t     p2_in_i,
  output pfs_pkg::pfs_nibble_t          p2_out_o,
  output pfs_pkg::pfs_nibble_t          p2_oe_o,
  output pfs_pkg::pfs_nibble_t          p2_pu_o
);

  import pfs_pkg::*;

  logic             ack_q;
  logic [DATA_W-1:0] rdat_q;
  logic [DATA_W-1:0] rdat_d;
  logic             lcd_sel_q;
  logic             ser_en_q;
  pfs_serial_mode_t ser_mode_q;
  pfs_nibble_t      p1_dat_q;
  pfs_nibble_t      p1_dir_q;
  pfs_nibble_t      p1_pul_q;
  pfs_nibble_t      p2_dat_q;
  pfs_nibble_t      p2_dir_q;
  pfs_nibble_t      p2_pul_q;
  pfs_nibble_t      sio_in_q;
  pfs_nibble_t      p1_claim;
  pfs_nibble_t      p2_claim;
  pfs_nibble_t      p2_alt_out;
  pfs_nibble_t      p1_alt_pu;
  pfs_nibble_t      p1_gpio_pu;
  pfs_nibble_t      p2_gpio_pu;
  logic             req;
  logic             wr_lo;
  logic [`PFS_IDX_W-1:0] idx;

  // Pins handed to the serial interface for a given enable and mode.
  function automatic pfs_nibble_t pfs_serial_claim(input logic en, input pfs_serial_mode_t mode);
    pfs_nibble_t m;
    m = `PFS_CLAIM_NONE;
    if (en) begin
      case (mode)
        PFS_SYNC_SLAVE:  m = `PFS_CLAIM_SLAVE;   // [RQ7] [RQ8]
        PFS_SYNC_MASTER: m = `PFS_CLAIM_MASTER;  // [RQ7] [RQ8]
        PFS_ASYNC_7BIT:  m = `PFS_CLAIM_ASYNC;   // [RQ6] [RQ8]
        PFS_ASYNC_8BIT:  m = `PFS_CLAIM_ASYNC;   // [RQ6] [RQ8]
        default:         m = `PFS_CLAIM_NONE;
      endcase
    end
    return m;
  endfunction

  // A port data read shows the terminal level on free input pins and the stored value elsewhere.
  // Claimed pins return storage only, since the pin no longer belongs to the port.
  function automatic pfs_nibble_t pfs_port_read(input pfs_nibble_t dat, input pfs_nibble_t dir,
                                                input pfs_nibble_t claim, input pfs_nibble_t pin);
    pfs_nibble_t r;
    r = (dat & (dir | claim)) | (pin & ~(dir | claim));  // [RQ3]
    return r;
  endfunction

  assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lo = req & wb_we_i & wb_sel_i[0];
  assign idx   = wb_adr_i[`PFS_ADR_W-1:2];

  assign p1_claim = pfs_serial_claim(ser_en_q, ser_mode_q);  // [RQ5]
  assign p2_claim = lcd_sel_q ? `PFS_CLAIM_LCD : `PFS_CLAIM_NONE;  // [RQ1]

  // Serial input pins keep honouring their pull-up bits; serial outputs never pull up.
  assign p1_alt_pu  = p1_pul_q & ~sio_oe_i;
  assign p1_gpio_pu = p1_pul_q & ~p1_dir_q;
  assign p2_gpio_pu = p2_pul_q & ~p2_dir_q;

  always_comb begin
    p2_alt_out = `PFS_CLAIM_NONE;
    p2_alt_out[`PFS_LCD_SYNC_BIT]  = lcd_line_sync_i;     // [RQ1]
    p2_alt_out[`PFS_LCD_FRAME_BIT] = lcd_frame_signal_i;  // [RQ1]
  end

  // Bus handshake: one ack per request, dropped in the following cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (req) begin
      rdat_q <= rdat_d;
    end
  end

  always_comb begin
    rdat_d = '0;
    case (idx)
      `PFS_IDX_LCD_SEL:  rdat_d[`PFS_BIT_LCD_SEL] = lcd_sel_q;  // [RQ4]
      `PFS_IDX_SER_MODE: begin
        rdat_d[`PFS_BIT_SER_EN]  = ser_en_q;       // [RQ5]
        rdat_d[`PFS_BIT_MODE_LO] = ser_mode_q[0];  // [RQ6]
        rdat_d[`PFS_BIT_MODE_HI] = ser_mode_q[1];  // [RQ6]
      end
      `PFS_IDX_P1_DAT:   rdat_d[3:0] = pfs_port_read(p1_dat_q, p1_dir_q, p1_claim, p1_in_i);
      `PFS_IDX_P1_DIR:   rdat_d[3:0] = p1_dir_q;  // [RQ3]
      `PFS_IDX_P1_PUL:   rdat_d[3:0] = p1_pul_q;
      `PFS_IDX_P2_DAT:   rdat_d[3:0] = pfs_port_read(p2_dat_q, p2_dir_q, p2_claim, p2_in_i);
      `PFS_IDX_P2_DIR:   rdat_d[3:0] = p2_dir_q;  // [RQ3]
      `PFS_IDX_P2_PUL:   rdat_d[3:0] = p2_pul_q;
      default:           rdat_d = '0;
    endcase
  end
  // Bit 3 of the serial mode word is left at zero above and has no storage.  [RQ9]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcd_sel_q <= `PFS_RST_LCD_SEL;  // [RQ4]
    end else if (wr_lo && idx == `PFS_IDX_LCD_SEL) begin
      lcd_sel_q <= wb_dat_i[`PFS_BIT_LCD_SEL];  // [RQ4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_en_q   <= `PFS_RST_SER_EN;  // [RQ5]
      ser_mode_q <= pfs_serial_mode_t'(`PFS_RST_MODE);  // [RQ6]
    end else if (wr_lo && idx == `PFS_IDX_SER_MODE) begin
      ser_en_q   <= wb_dat_i[`PFS_BIT_SER_EN];  // [RQ5]
      ser_mode_q <= pfs_serial_mode_t'({wb_dat_i[`PFS_BIT_MODE_HI], wb_dat_i[`PFS_BIT_MODE_LO]});  // [RQ6] [RQ7]
    end
  end

  // Port control storage stays writable whatever the pin function is.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_dat_q <= `PFS_RST_DAT;
      p1_dir_q <= `PFS_RST_DIR;
      p1_pul_q <= `PFS_RST_PUL;
    end else if (wr_lo) begin
      if (idx == `PFS_IDX_P1_DAT) begin
        p1_dat_q <= wb_dat_i[3:0];  // [RQ3]
      end
      if (idx == `PFS_IDX_P1_DIR) begin
        p1_dir_q <= wb_dat_i[3:0];  // [RQ3]
      end
      if (idx == `PFS_IDX_P1_PUL) begin
        p1_pul_q <= wb_dat_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p2_dat_q <= `PFS_RST_DAT;
      p2_dir_q <= `PFS_RST_DIR;
      p2_pul_q <= `PFS_RST_PUL;
    end else if (wr_lo) begin
      if (idx == `PFS_IDX_P2_DAT) begin
        p2_dat_q <= wb_dat_i[3:0];  // [RQ3]
      end
      if (idx == `PFS_IDX_P2_DIR) begin
        p2_dir_q <= wb_dat_i[3:0];  // [RQ3]
      end
      if (idx == `PFS_IDX_P2_PUL) begin
        p2_pul_q <= wb_dat_i[3:0];
      end
    end
  end

  // Unclaimed serial pins feed zero to the serial interface so it never sees port traffic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sio_in_q <= `PFS_CLAIM_NONE;
    end else begin
      sio_in_q <= p1_in_i & p1_claim;  // [RQ8]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pins
      pfs_pin_slot u_p1 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .claim_i    (p1_claim[g]),
        .alt_out_i  (sio_out_i[g]),
        .alt_oe_i   (sio_oe_i[g]),
        .alt_pu_i   (p1_alt_pu[g]),
        .gpio_out_i (p1_dat_q[g]),
        .gpio_oe_i  (p1_dir_q[g]),
        .gpio_pu_i  (p1_gpio_pu[g]),
        .pin_out_o  (p1_out_o[g]),
        .pin_oe_o   (p1_oe_o[g]),
        .pin_pu_o   (p1_pu_o[g])
      );
      // The LCD pins are switched on the edge after the select changes, with no extra sequencing.
      pfs_pin_slot u_p2 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .claim_i    (p2_claim[g]),  // [RQ2]
        .alt_out_i  (p2_alt_out[g]),
        .alt_oe_i   (1'b1),  // [RQ1]
        .alt_pu_i   (1'b0),
        .gpio_out_i (p2_dat_q[g]),
        .gpio_oe_i  (p2_dir_q[g]),
        .gpio_pu_i  (p2_gpio_pu[g]),
        .pin_out_o  (p2_out_o[g]),
        .pin_oe_o   (p2_oe_o[g]),
        .pin_pu_o   (p2_pu_o[g])
      );
    end
  endgenerate

  assign wb_ack_o               = ack_q;
  assign wb_dat_o               = rdat_q;
  assign sio_in_o               = sio_in_q;
  assign serial_enable_o        = ser_en_q;
  assign serial_mode_o          = ser_mode_q;
  assign lcd_expansion_select_o = lcd_sel_q;

endmodule // pfs_port_function_select

`default_nettype wire

// [pfs_end_marker_unused.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [pfs_port_function_select_properties.sv]
// Purpose: Port-level properties of the port function select block.
// Assumes: Pin outputs follow their source one clock later.
// Notes: Bound to the block below the module.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_map.svh"
module pfs_checker #(
  parameter int DATA_W = 32
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [`PFS_ADR_W-1:0]     wb_adr_i,
  input wire logic [DATA_W-1:0]         wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      lcd_line_sync_i,
  input wire logic                      lcd_frame_signal_i,
  input wire pfs_pkg::pfs_nibble_t      sio_out_i,
  input wire pfs_pkg::pfs_nibble_t      sio_in_o,
  input wire logic                      serial_enable_o,
  input wire pfs_pkg::pfs_serial_mode_t serial_mode_o,
  input wire logic                      lcd_expansion_select_o,
  input wire pfs_pkg::pfs_nibble_t      p1_out_o,
  input wire pfs_pkg::pfs_nibble_t      p2_out_o,
  input wire pfs_pkg::pfs_nibble_t      p2_oe_o
);
  import pfs_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  lcd_route_a:
    assert property (lcd_expansion_select_o |=> p2_out_o[3:2] == $past({lcd_frame_signal_i, lcd_line_sync_i})
      && p2_oe_o[3:2] == 2'h3) else $error("lcd pins not routed");
  slave_claim_a:
    assert property (serial_enable_o && serial_mode_o == PFS_SYNC_SLAVE |=> p1_out_o == $past(sio_out_i))
      else $error("slave pins not serial");
  master_claim_a:
    assert property (serial_enable_o && serial_mode_o == PFS_SYNC_MASTER |=> p1_out_o[2:0] == $past(sio_out_i[2:0]))
      else $error("master pins not serial");
  async_claim_a:
    assert property (serial_enable_o && serial_mode_o[1] |=> p1_out_o[1:0] == $past(sio_out_i[1:0]))
      else $error("async pins not serial");
  serial_off_a:
    assert property (!serial_enable_o |=> sio_in_o == 4'h0) else $error("serial input while disabled");
  ack_req_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  mode_read_a:
    assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[17:2]) == `PFS_IDX_SER_MODE
      |-> wb_dat_o[3:0] == {1'b0, serial_mode_o, serial_enable_o}) else $error("mode read wrong");
  lcd_read_a:
    assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[17:2]) == `PFS_IDX_LCD_SEL
      |-> wb_dat_o[3] == lcd_expansion_select_o) else $error("lcd select read wrong");
  lcd_c: cover property (lcd_expansion_select_o);
  slave_c: cover property (serial_enable_o && serial_mode_o == PFS_SYNC_SLAVE);
  read_c: cover property (wb_ack_o && !wb_we_i);
endmodule // pfs_checker
bind pfs_port_function_select pfs_checker #(.DATA_W(DATA_W)) pfs_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lcd_line_sync_i(lcd_line_sync_i),
  .lcd_frame_signal_i(lcd_frame_signal_i), .sio_out_i(sio_out_i), .sio_in_o(sio_in_o),
  .serial_enable_o(serial_enable_o), .serial_mode_o(serial_mode_o),
  .lcd_expansion_select_o(lcd_expansion_select_o), .p1_out_o(p1_out_o), .p2_out_o(p2_out_o),
  .p2_oe_o(p2_oe_o));
`default_nettype wire

// [pfs_pin_peer.sv]
// Purpose: Pin-side model that turns drive, enable and pull-up into pin levels.
// Assumes: No outside party drives the pins.
// Notes: An undriven pin without pull-up toggles each cycle, so no steady guess can pass.
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_peer (
  input  wire logic                 clk_i,
  input  wire pfs_pkg::pfs_nibble_t out_i,
  input  wire pfs_pkg::pfs_nibble_t oe_i,
  input  wire pfs_pkg::pfs_nibble_t pu_i,
  output pfs_pkg::pfs_nibble_t      lvl_o
);
  import pfs_pkg::*;
  pfs_nibble_t float_q;
  always_ff @(posedge clk_i) float_q <= (float_q === 4'h5) ? 4'ha : 4'h5;
  assign lvl_o = (oe_i & out_i) | (~oe_i & (pu_i | float_q));
endmodule // pfs_pin_peer
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the port function select block.
// Assumes: Registers sit at byte address four times their index.
// Notes: Pin levels come from the pin-side models, not from the bench.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_map.svh"
module tb_top;
  import pfs_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             req = 1'b0;
  logic             we = 1'b0;
  logic             sync = 1'b0;
  logic             frame = 1'b0;
  logic [17:0]      adr = 18'h0;
  logic [31:0]      wdat = 32'h0;
  logic [31:0]      rdat;
  logic [31:0]      dat_o;
  logic             ack;
  logic             ser_en;
  logic             lcd_sel;
  pfs_serial_mode_t mode_o;
  pfs_nibble_t      sio_out = 4'h0;
  pfs_nibble_t      sio_oe = 4'h0;
  pfs_nibble_t      sio_in, p1_in, p1_out, p1_oe, p1_pu, p2_in, p2_out, p2_oe, p2_pu;
  pfs_nibble_t      claim [4] = '{4'h7, 4'hf, 4'h3, 4'h3};
  int               bad_count = 0;
  int               cmp_count = 0;
  int               cycles = 0;
  pfs_port_function_select #(.DATA_W(32)) pfs_port_function_select_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .lcd_line_sync_i(sync),
    .lcd_frame_signal_i(frame), .sio_out_i(sio_out), .sio_oe_i(sio_oe), .sio_in_o(sio_in),
    .serial_enable_o(ser_en), .serial_mode_o(mode_o), .lcd_expansion_select_o(lcd_sel),
    .p1_in_i(p1_in), .p1_out_o(p1_out), .p1_oe_o(p1_oe), .p1_pu_o(p1_pu), .p2_in_i(p2_in),
    .p2_out_o(p2_out), .p2_oe_o(p2_oe), .p2_pu_o(p2_pu));
  pfs_pin_peer p1_peer (.clk_i(clk_i), .out_i(p1_out), .oe_i(p1_oe), .pu_i(p1_pu), .lvl_o(p1_in));
  pfs_pin_peer p2_peer (.clk_i(clk_i), .out_i(p2_out), .oe_i(p2_oe), .pu_i(p2_pu), .lvl_o(p2_in));
  initial forever #4 clk_i = ~clk_i;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // The whole run needs about a hundred and ten cycles; the ceiling leaves ample margin.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request is held until ack is sampled high, then released for at least one cycle.
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    // Only the bench's cycle ceiling ends a wait that never sees ack.
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    req <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(what, rdat, exp);
  endtask
  task automatic settle();
    // Ends on an edge, so later stimulus stays edge-aligned and reads see the settled values.
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("lcd select reset", `PFS_IDX_LCD_SEL, 32'h0);
    rd_chk("mode reset", `PFS_IDX_SER_MODE, 32'h0);
    rd_chk("unmapped read", 16'hff62, 32'h0);
    check("reset pins", {p1_oe, p1_pu, p2_oe, p2_pu}, 32'h0f0f);
    $display("test reset done");
    xfer(1'b1, `PFS_IDX_P2_DAT, 32'h3);
    xfer(1'b1, `PFS_IDX_P2_DIR, 32'hf);
    xfer(1'b1, `PFS_IDX_LCD_SEL, 32'h8);
    sync <= 1'b1;
    settle();
    check("lcd pins", {lcd_sel, p2_oe, p2_out}, 32'h1f7);
    frame <= 1'b1;
    sync <= 1'b0;
    xfer(1'b1, `PFS_IDX_P2_DAT, 32'hc);
    settle();
    check("lcd pins frame", {p2_pu, p2_out}, 32'h08);
    rd_chk("claimed data store", `PFS_IDX_P2_DAT, 32'hc);
    rd_chk("claimed dir store", `PFS_IDX_P2_DIR, 32'hf);
    rd_chk("lcd select read", `PFS_IDX_LCD_SEL, 32'h8);
    xfer(1'b1, `PFS_IDX_LCD_SEL, 32'h0);
    settle();
    check("port pins back", p2_out, 32'hc);
    $display("test lcd done");
    // Port 1 stays in input mode with pull-ups, so unclaimed pins read high and must be masked.
    sio_out <= 4'hf;
    sio_oe <= 4'hf;
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, `PFS_IDX_SER_MODE, 32'(9 | (m << 1)));
      rd_chk("mode read", `PFS_IDX_SER_MODE, 32'(1 | (m << 1)));
      settle();
      check("mode out", {mode_o, ser_en}, 32'(1 | (m << 1)));
      check("serial claim", p1_out, claim[m]);
      check("serial input", sio_in, claim[m]);
      check("serial oe pu", {claim[m], ~claim[m]}, {p1_oe, p1_pu});
      rd_chk("claimed port read", `PFS_IDX_P1_DAT, {28'h0, ~claim[m]});
    end
    xfer(1'b1, `PFS_IDX_SER_MODE, 32'h6);
    settle();
    check("serial off pins", {sio_in, p1_out, p1_oe, p1_pu}, 32'h000f);
    rd_chk("port pin read", `PFS_IDX_P1_DAT, 32'hf);
    $display("test serial done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
